// [hdl/axis_cfg.svh]
`ifndef AXIS_CFG_SVH
`define AXIS_CFG_SVH

// Register word offsets on the plain register port
`define REG_CTRL        4'h0
`define REG_MODE        4'h1
`define REG_KICK        4'h2
`define REG_STATUS      4'h3
`define REG_POS0        4'h4
`define REG_POS1        4'h5
`define REG_IDXPOS0     4'h6
`define REG_IDXPOS1     4'h7
`define REG_WD_TIMEOUT  4'h8

// Control register fields
`define CTRL_SERVO_HERE 0
`define CTRL_MOTOR_OFF  1
`define CTRL_DIFF_EN    2
`define CTRL_IDX_CLR    3
`define CTRL_PULSE_DIR0 4
`define CTRL_PULSE_DIR1 5

// Mode register codes
`define MODE_SERVO      2'h0
`define MODE_STEPPER    2'h1
`define MODE_COMMUTATE  2'h2

// Watchdog service key
`define WD_KEY          16'h5a5a

// Encoder rate limits
`define ENC_MAX_CYC_HZ  3000000
`define ENC_MAX_CNT_HZ  12000000
`define CLK_HZ          100000000
// Least cycles between two quadrature edges
`define ENC_MIN_CYC     ((`CLK_HZ + `ENC_MAX_CNT_HZ - 1) / `ENC_MAX_CNT_HZ)

// Watchdog default timeout, 10 ms in microseconds
`define WD_TIMEOUT_US   10000
`define WD_TIMEOUT_CYC  (`WD_TIMEOUT_US * (`CLK_HZ / 1000000))

// Step pulse width in cycles
`define STEP_WIDTH      8'h04

`endif

// [hdl/axis_pkg.sv]
package axis_pkg;
  typedef enum logic [1:0] {
    WD_POWERUP,
    WD_RUN,
    WD_TRIP
  } wd_state_t;

  typedef logic [31:0] pos_t;
endpackage

// [hdl/enc_decoder.sv]
`timescale 1ns/1ns
`include "axis_cfg.svh"

module enc_decoder
  import axis_pkg::*;
#(
  parameter int POS_W = 32
) (
  input  wire logic             ref_clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic             enc_phase_a_i,
  input  wire logic             enc_phase_a_n_i,
  input  wire logic             enc_phase_b_i,
  input  wire logic             enc_phase_b_n_i,
  input  wire logic             enc_index_i,
  input  wire logic             diff_en_i,
  input  wire logic             pulse_dir_i,
  input  wire logic             idx_clr_i,
  output logic [POS_W-1:0]      pos_o,
  output logic [POS_W-1:0]      idx_pos_o,
  output logic                  idx_seen_o
);

  logic             a_in;
  logic             b_in;
  logic [1:0]       ab_r;
  logic [1:0]       ab_nxt;
  logic             idx_r;
  logic             idx_nxt;
  logic [POS_W-1:0] pos_r;
  logic [POS_W-1:0] pos_nxt;
  logic [POS_W-1:0] idx_pos_r;
  logic [POS_W-1:0] idx_pos_nxt;
  logic             idx_seen_r;
  logic             idx_seen_nxt;
  logic             up;
  logic             dn;
  logic             prime_r;
  logic             prime_nxt;

  // Differential pairs count only when both halves agree
  always_comb begin
    if (diff_en_i) begin
      a_in = enc_phase_a_i & ~enc_phase_a_n_i;
      b_in = enc_phase_b_i & ~enc_phase_b_n_i;
    end else begin
      a_in = enc_phase_a_i;
      b_in = enc_phase_b_i;
    end
  end

  // Gray order gives four counts per cycle, direction from phase order
  always_comb begin
    up = 1'b0;
    dn = 1'b0;
    ab_nxt = {a_in, b_in};
    idx_nxt = enc_index_i;
    prime_nxt = 1'b1;
    if (pulse_dir_i) begin
      // Step on rising a edge, b is direction
      up = a_in & ~ab_r[1] & b_in;
      dn = a_in & ~ab_r[1] & ~b_in;
    end else begin
      unique case ({ab_r, a_in, b_in})
        4'b0001, 4'b0111, 4'b1110, 4'b1000: up = 1'b1;
        4'b0010, 4'b1011, 4'b1101, 4'b0100: dn = 1'b1;
        default: ;
      endcase
    end
    // First cycle after reset only loads history; a parked phase is no step
    if (!prime_r) begin
      up = 1'b0;
      dn = 1'b0;
    end
    pos_nxt = pos_r;
    if (up) begin
      pos_nxt = pos_r + POS_W'(1);
    end else if (dn) begin
      pos_nxt = pos_r - POS_W'(1);
    end
    idx_pos_nxt = idx_pos_r;
    idx_seen_nxt = idx_seen_r;
    if (idx_clr_i) begin
      idx_seen_nxt = 1'b0;
    end
    // Index edge latches the count as reference; set wins over clear
    if (prime_r & enc_index_i & ~idx_r) begin
      idx_pos_nxt = pos_nxt;
      idx_seen_nxt = 1'b1;
    end
  end

  // Decoder state registers; every clock samples so 12 MHz edges are caught
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ab_r       <= 2'h0;
      idx_r      <= 1'b0;
      pos_r      <= '0;
      idx_pos_r  <= '0;
      idx_seen_r <= 1'b0;
      prime_r    <= 1'b0;
    end else begin
      ab_r       <= ab_nxt;
      idx_r      <= idx_nxt;
      pos_r      <= pos_nxt;
      idx_pos_r  <= idx_pos_nxt;
      idx_seen_r <= idx_seen_nxt;
      prime_r    <= prime_nxt;
    end
  end

  assign pos_o      = pos_r;
  assign idx_pos_o  = idx_pos_r;
  assign idx_seen_o = idx_seen_r;

  // Quadrature up step from 00 to 01 moves the count by exactly one
  chk_quad_step: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (prime_r && !pulse_dir_i && ab_r == 2'b00 && {a_in, b_in} == 2'b01) |=> pos_r == $past(pos_r) + POS_W'(1))
    else $error("quadrature up step not counted");

  chk_index_latch: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (prime_r && enc_index_i && !idx_r) |=> idx_seen_r && idx_pos_r == pos_r)
    else $error("index edge did not latch position");

  chk_pulse_dir: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (prime_r && pulse_dir_i && a_in && !ab_r[1] && !b_in) |=> pos_r == $past(pos_r) - POS_W'(1))
    else $error("pulse with low direction did not count down");

  chk_diff_reject: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (diff_en_i && enc_phase_a_i && enc_phase_a_n_i) |-> !a_in)
    else $error("invalid differential pair accepted");

endmodule

// [hdl/axis_interface.sv]
`timescale 1ns/1ns
`include "axis_cfg.svh"


module axis_interface
  import axis_pkg::*;
#(
  parameter int          POS_W       = 32,
  parameter int          NUM_AXES    = 2,
  parameter logic [31:0] WD_TIMEOUT  = `WD_TIMEOUT_CYC
) (
  input  wire logic                ref_clk_i,
  input  wire logic                sys_rst_i,
  input  wire logic [3:0]          reg_addr_i,
  input  wire logic [31:0]         reg_wdata_i,
  input  wire logic                reg_wr_i,
  input  wire logic                reg_rd_i,
  output logic [31:0]              reg_rdata_o,
  input  wire logic [NUM_AXES-1:0] enc_phase_a_i,
  input  wire logic [NUM_AXES-1:0] enc_phase_a_n_i,
  input  wire logic [NUM_AXES-1:0] enc_phase_b_i,
  input  wire logic [NUM_AXES-1:0] enc_phase_b_n_i,
  input  wire logic [NUM_AXES-1:0] enc_index_i,
  input  wire logic                stepper_jumper_i,
  input  wire logic                motor_off_default_i,
  input  wire logic [15:0]         motor_cmd_i,
  output logic                     amp_enable_out_o,
  output logic [NUM_AXES-1:0]      axis_error_o,
  output logic [15:0]              dac0_o,
  output logic [15:0]              dac1_o,
  output logic                     dac1_en_o,
  output logic                     step_o,
  output logic                     dir_o,
  output logic [1:0]               axis_slots_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Encoder decoders, one per axis

  logic             diff_en_r;
  logic [1:0]       pulse_dir_r;
  logic             idx_clr_pulse;
  logic [POS_W-1:0] pos     [NUM_AXES];
  logic [POS_W-1:0] idx_pos [NUM_AXES];
  logic [NUM_AXES-1:0] idx_seen;

  for (genvar g = 0; g < NUM_AXES; g++) begin : g_axis
    enc_decoder #(
      .POS_W (POS_W)
    ) u_dec (
      .ref_clk_i       (ref_clk_i),
      .sys_rst_i       (sys_rst_i),
      .enc_phase_a_i   (enc_phase_a_i[g]),
      .enc_phase_a_n_i (enc_phase_a_n_i[g]),
      .enc_phase_b_i   (enc_phase_b_i[g]),
      .enc_phase_b_n_i (enc_phase_b_n_i[g]),
      .enc_index_i     (enc_index_i[g]),
      .diff_en_i       (diff_en_r),
      .pulse_dir_i     (pulse_dir_r[g % 2]),
      .idx_clr_i       (idx_clr_pulse),
      .pos_o           (pos[g]),
      .idx_pos_o       (idx_pos[g]),
      .idx_seen_o      (idx_seen[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers and strap capture

  logic        servo_here_cmd_r;
  logic        servo_here_cmd_nxt;
  logic        mo_strap_r;
  logic        mo_strap_nxt;
  logic        strap_done_r;
  logic        strap_done_nxt;
  logic [1:0]  motor_type_cmd_r;
  logic [1:0]  motor_type_cmd_nxt;
  logic        diff_en_nxt;
  logic [1:0]  pulse_dir_nxt;
  logic [31:0] wd_timeout_r;
  logic [31:0] wd_timeout_nxt;
  logic        wr_ctrl;
  logic        kick;

  assign wr_ctrl       = reg_wr_i && reg_addr_i == `REG_CTRL;
  assign kick          = reg_wr_i && reg_addr_i == `REG_KICK && reg_wdata_i[15:0] == `WD_KEY;
  assign idx_clr_pulse = wr_ctrl && reg_wdata_i[`CTRL_IDX_CLR];

  // Strap caught one cycle after reset release, not under the reset
  always_comb begin
    strap_done_nxt     = 1'b1;
    mo_strap_nxt       = strap_done_r ? mo_strap_r : motor_off_default_i;
    servo_here_cmd_nxt = servo_here_cmd_r;
    if (!strap_done_r) begin
      // Without the motor-off jumper the servo comes up on
      servo_here_cmd_nxt = ~motor_off_default_i;
    end
    diff_en_nxt        = diff_en_r;
    pulse_dir_nxt      = pulse_dir_r;
    motor_type_cmd_nxt = motor_type_cmd_r;
    wd_timeout_nxt     = wd_timeout_r;
    if (wr_ctrl) begin
      if (reg_wdata_i[`CTRL_SERVO_HERE]) begin
        servo_here_cmd_nxt = 1'b1;
      end else if (reg_wdata_i[`CTRL_MOTOR_OFF]) begin
        servo_here_cmd_nxt = 1'b0;
      end
      diff_en_nxt   = reg_wdata_i[`CTRL_DIFF_EN];
      pulse_dir_nxt = reg_wdata_i[`CTRL_PULSE_DIR1:`CTRL_PULSE_DIR0];
    end
    if (reg_wr_i && reg_addr_i == `REG_MODE) begin
      motor_type_cmd_nxt = reg_wdata_i[1:0];
    end
    if (reg_wr_i && reg_addr_i == `REG_WD_TIMEOUT) begin
      wd_timeout_nxt = reg_wdata_i;
    end
  end

  // Configuration flops
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      strap_done_r     <= 1'b0;
      mo_strap_r       <= 1'b0;
      servo_here_cmd_r <= 1'b0;
      diff_en_r        <= 1'b0;
      pulse_dir_r      <= 2'h0;
      motor_type_cmd_r <= `MODE_SERVO;
      wd_timeout_r     <= WD_TIMEOUT;
    end else begin
      strap_done_r     <= strap_done_nxt;
      mo_strap_r       <= mo_strap_nxt;
      servo_here_cmd_r <= servo_here_cmd_nxt;
      diff_en_r        <= diff_en_nxt;
      pulse_dir_r      <= pulse_dir_nxt;
      motor_type_cmd_r <= motor_type_cmd_nxt;
      wd_timeout_r     <= wd_timeout_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog: power-up hold, run, latched trip

  wd_state_t   wd_state_r;
  wd_state_t   wd_state_nxt;
  logic [31:0] wd_cnt_r;
  logic [31:0] wd_cnt_nxt;

  // The first service ends power-up; a missed one trips for good
  always_comb begin
    wd_state_nxt = wd_state_r;
    wd_cnt_nxt   = wd_cnt_r;
    unique case (wd_state_r)
      WD_POWERUP: begin
        wd_cnt_nxt = 32'h0;
        if (kick && strap_done_r) begin
          wd_state_nxt = WD_RUN;
        end
      end
      WD_RUN: begin
        if (kick) begin
          wd_cnt_nxt = 32'h0;
        end else if (wd_cnt_r >= wd_timeout_r - 32'h1) begin
          wd_state_nxt = WD_TRIP;
        end else begin
          wd_cnt_nxt = wd_cnt_r + 32'h1;
        end
      end
      WD_TRIP: begin
        wd_state_nxt = WD_TRIP; // Only reset leaves here
      end
      default: begin
        wd_state_nxt = WD_TRIP;
      end
    endcase
  end

  // Watchdog flops
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wd_state_r <= WD_POWERUP;
      wd_cnt_r   <= 32'h0;
    end else begin
      wd_state_r <= wd_state_nxt;
      wd_cnt_r   <= wd_cnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output mode selection and pin drive

  logic                amp_en_r;
  logic                amp_en_nxt;
  logic [NUM_AXES-1:0] err_r;
  logic [NUM_AXES-1:0] err_nxt;
  logic [15:0]         dac0_r;
  logic [15:0]         dac0_nxt;
  logic [15:0]         dac1_r;
  logic [15:0]         dac1_nxt;
  logic                dac1_en_r;
  logic                dac1_en_nxt;
  logic                step_r;
  logic                step_nxt;
  logic                dir_r;
  logic                dir_nxt;
  logic [1:0]          slots_r;
  logic [1:0]          slots_nxt;
  logic [7:0]          step_cnt_r;
  logic [7:0]          step_cnt_nxt;
  logic [15:0]         step_acc_r;
  logic [15:0]         step_acc_nxt;
  logic                stepper_mode;
  logic                commutate_mode;
  logic                wd_ok;

  // Stepper needs both the jumper and the motor-type command
  assign stepper_mode   = stepper_jumper_i && motor_type_cmd_r == `MODE_STEPPER;
  assign commutate_mode = motor_type_cmd_r == `MODE_COMMUTATE;
  assign wd_ok          = wd_state_r == WD_RUN;

  // Drive values; analog word reused as step rate in stepper mode
  always_comb begin
    amp_en_nxt   = wd_ok && servo_here_cmd_r;
    err_nxt      = wd_ok ? '0 : '1;
    dac0_nxt     = 16'h0;
    dac1_nxt     = 16'h0;
    dac1_en_nxt  = 1'b0;
    step_nxt     = 1'b0;
    dir_nxt      = dir_r;
    step_cnt_nxt = step_cnt_r;
    step_acc_nxt = step_acc_r;
    // Two-axis build keeps both slots even when one axis commutates
    slots_nxt    = NUM_AXES > 1 ? 2'h2 : 2'h1;
    if (amp_en_nxt) begin
      if (stepper_mode) begin
        // Analog command held off, step and direction drive the pins
        dir_nxt = motor_cmd_i[15];
        if (step_cnt_r != 8'h0) begin
          step_cnt_nxt = step_cnt_r - 8'h1;
          step_nxt     = 1'b1;
        end else begin
          {step_nxt, step_acc_nxt} = {1'b0, step_acc_r} + {1'b0, motor_cmd_i[15] ? -motor_cmd_i : motor_cmd_i};
          if (step_nxt) begin
            step_cnt_nxt = `STEP_WIDTH - 8'h1;
          end
        end
      end else if (commutate_mode) begin
        // Second DAC carries the second phase
        dac0_nxt    = motor_cmd_i;
        dac1_nxt    = -motor_cmd_i;
        dac1_en_nxt = 1'b1;
      end else begin
        dac0_nxt = motor_cmd_i;
      end
    end
  end

  // Output flops
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      amp_en_r   <= 1'b0;
      err_r      <= '1;
      dac0_r     <= 16'h0;
      dac1_r     <= 16'h0;
      dac1_en_r  <= 1'b0;
      step_r     <= 1'b0;
      dir_r      <= 1'b0;
      slots_r    <= 2'h0;
      step_cnt_r <= 8'h0;
      step_acc_r <= 16'h0;
    end else begin
      amp_en_r   <= amp_en_nxt;
      err_r      <= err_nxt;
      dac0_r     <= dac0_nxt;
      dac1_r     <= dac1_nxt;
      dac1_en_r  <= dac1_en_nxt;
      step_r     <= step_nxt;
      dir_r      <= dir_nxt;
      slots_r    <= slots_nxt;
      step_cnt_r <= step_cnt_nxt;
      step_acc_r <= step_acc_nxt;
    end
  end

  assign amp_enable_out_o = amp_en_r;
  assign axis_error_o     = err_r;
  assign dac0_o           = dac0_r;
  assign dac1_o           = dac1_r;
  assign dac1_en_o        = dac1_en_r;
  assign step_o           = step_r;
  assign dir_o            = dir_r;
  assign axis_slots_o     = slots_r;

  ////////////////////////////////////////////////////////////////////////////
  // Register read port, data one cycle after the strobe

  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;

  // Unmapped addresses read zero
  always_comb begin
    rdata_nxt = 32'h0;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        `REG_CTRL:       rdata_nxt = {26'h0, pulse_dir_r, 1'b0, diff_en_r, ~servo_here_cmd_r, servo_here_cmd_r};
        `REG_MODE:       rdata_nxt = {30'h0, motor_type_cmd_r};
        `REG_STATUS:     rdata_nxt = {24'h0, slots_r, stepper_mode, idx_seen[0], mo_strap_r,
                                      wd_state_r == WD_TRIP, wd_ok, amp_en_r};
        `REG_POS0:       rdata_nxt = 32'(pos[0]);
        `REG_POS1:       rdata_nxt = 32'(pos[NUM_AXES-1]);
        `REG_IDXPOS0:    rdata_nxt = 32'(idx_pos[0]);
        `REG_IDXPOS1:    rdata_nxt = 32'(idx_pos[NUM_AXES-1]);
        `REG_WD_TIMEOUT: rdata_nxt = wd_timeout_r;
        default:         rdata_nxt = 32'h0;
      endcase
    end
  end

  // Read data flop
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_r <= 32'h0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata_o = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  chk_trip_latched: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    wd_state_r == WD_TRIP |=> wd_state_r == WD_TRIP && !amp_en_r)
    else $error("watchdog trip released without reset");

  chk_amp_err_tie: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    !wd_ok |=> !amp_en_r && err_r == '1)
    else $error("amp enable or error wrong while watchdog not running");

  chk_wd_timeout: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (wd_ok && !kick && wd_cnt_r == wd_timeout_r - 32'h1) |=> wd_state_r == WD_TRIP)
    else $error("watchdog did not trip on timeout");

  chk_amp_run: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (wd_ok && servo_here_cmd_r) |=> amp_en_r)
    else $error("amp enable low in normal run");

  chk_stepper_gate: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    step_r |-> $past(stepper_jumper_i) && $past(motor_type_cmd_r) == `MODE_STEPPER)
    else $error("step pulse without jumper and command");

  chk_step_analog_off: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    $past(stepper_mode) |-> dac0_r == 16'h0)
    else $error("analog command live in stepper mode");

  chk_commutate_dac: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (amp_en_nxt && commutate_mode && !stepper_mode) |=> dac1_en_r)
    else $error("second dac not enabled in commutation");

  chk_motor_off_hold: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (!servo_here_cmd_r && strap_done_r) |=> !amp_en_r)
    else $error("amp enabled before servo-here");

endmodule

// [sim/axis_partner_model.sv]
`timescale 1ns/1ns

////////////////////////////////////////////////////////////
// Encoder feeding both axes, plus a step-counting drive
module axis_partner_model #(
  parameter int GAP = 9
) (
  input  wire logic   ref_clk_i,
  input  wire logic   start_i,
  input  wire logic [7:0] steps_i,
  input  wire logic   up_i,
  input  wire logic   pd_i,
  input  wire logic   amp_en_i,
  input  wire logic   step_i,
  output logic        enc_a_o,
  output logic        enc_a_n_o,
  output logic        enc_b_o,
  output logic        enc_b_n_o,
  output logic        busy_o,
  output logic [15:0] step_cnt_o
);
  logic [15:0] stp_cnt_r = 16'h0;
  logic [8:0] rem_r = 9'h0;
  logic [7:0] gap_r = 8'h0;
  logic [1:0] q_r   = 2'h0;
  logic       pa_r  = 1'b0;
  logic       stp_q = 1'b0;

  // Edges GAP cycles apart; 9 is the top count rate at 100 MHz
  always @(posedge ref_clk_i) begin
    if (start_i) begin
      rem_r <= pd_i ? {steps_i, 1'b0} : {1'b0, steps_i};
      gap_r <= 8'h0;
    end else if (rem_r != 9'h0) begin
      gap_r <= (gap_r == 8'(GAP - 1)) ? 8'h0 : gap_r + 8'h1;
      if (gap_r == 8'(GAP - 1)) begin
        rem_r <= rem_r - 9'h1;
        pa_r  <= pd_i ? ~pa_r : pa_r;
        q_r   <= pd_i ? q_r : (up_i ? q_r + 2'h1 : q_r - 2'h1);
      end
    end
  end

  // Gray order 00,01,11,10 runs up; pulse mode puts direction on B
  assign enc_a_o   = pd_i ? pa_r : q_r[1];
  assign enc_b_o   = pd_i ? up_i : ^q_r;
  assign enc_a_n_o = ~enc_a_o;
  assign enc_b_n_o = ~enc_b_o;
  assign busy_o    = rem_r != 9'h0;
  assign step_cnt_o = stp_cnt_r;

  // A real drive ignores steps while disabled
  always @(posedge ref_clk_i) begin
    stp_q <= step_i;
    if (amp_en_i && step_i && !stp_q) begin
      stp_cnt_r <= stp_cnt_r + 16'h1;
    end
  end
endmodule

// [sim/tb_encoder_watchdog_axis_interface.sv]
`timescale 1ns/1ns
`include "axis_cfg.svh"

module tb_encoder_watchdog_axis_interface;
  localparam int WD = 300;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic        wr_s = 1'b0;
  logic        rd_s = 1'b0;
  logic        stj = 1'b0;
  logic        moj = 1'b0;
  logic [15:0] cmd = 16'h1234;
  logic [1:0]  idx = 2'h0;
  logic        go = 1'b0;
  logic [7:0]  nst = 8'h0;
  logic        up = 1'b1;
  logic        pd = 1'b0;
  logic        cm = 1'b0;
  logic        ea, ea_n, eb, eb_n, busy, amp, d1en, step, dir;
  logic [1:0]  err, slots;
  logic [15:0] d0, d1, scnt;
  logic [31:0] rdata, v, p0;
  int          n;
  int          miscompares = 0;
  int          total_checks = 0;

  ////////////////////////////////////////////////////////////
  // Both axes share one encoder so their counts must agree
  axis_interface #(.WD_TIMEOUT(32'd300)) dut_u (
    .ref_clk_i(clk), .sys_rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata),
    .enc_phase_a_i({2{ea}}), .enc_phase_a_n_i({2{cm ? ea : ea_n}}),
    .enc_phase_b_i({2{eb}}), .enc_phase_b_n_i({2{cm ? eb : eb_n}}),
    .enc_index_i(idx), .stepper_jumper_i(stj), .motor_off_default_i(moj),
    .motor_cmd_i(cmd), .amp_enable_out_o(amp), .axis_error_o(err), .dac0_o(d0),
    .dac1_o(d1), .dac1_en_o(d1en), .step_o(step), .dir_o(dir), .axis_slots_o(slots));

  axis_partner_model partner_u (
    .ref_clk_i(clk), .start_i(go), .steps_i(nst), .up_i(up), .pd_i(pd), .amp_en_i(amp),
    .step_i(step), .enc_a_o(ea), .enc_a_n_o(ea_n), .enc_b_o(eb), .enc_b_n_o(eb_n),
    .busy_o(busy), .step_cnt_o(scnt));

  always #5 clk = ~clk;

  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Bus cycles: one strobe cycle, then a quiet cycle
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clk);
    wr_s  <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 d = rdata;
    @(posedge clk);
  endtask

  task automatic kick();
    wr(`REG_KICK, {16'h0, `WD_KEY});
  endtask

  task automatic do_reset();
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  // Moves the encoder and compares the count change on both axes
  task automatic enc_case(input logic [7:0] k, input logic u, input logic m, input logic [31:0] dl);
    kick();
    rd(`REG_POS0, p0);
    nst <= k;
    up  <= u;
    pd  <= m;
    go  <= 1'b1;
    @(posedge clk);
    go  <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 3000 && busy; i++) @(posedge clk);
    repeat (4) @(posedge clk);
    rd(`REG_POS0, v);
    chk(v - p0, dl);
    rd(`REG_POS1, v);
    chk(v - p0, dl);
  endtask

  ////////////////////////////////////////////////////////////
  task automatic t_power();
    @(negedge clk);
    chk(amp, 1'b0);
    chk(err, 2'b11);
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    wr(`REG_KICK, 32'h1111);
    repeat (3) @(negedge clk);
    chk(amp, 1'b0);
    @(posedge clk);
    kick();
    repeat (2) @(negedge clk);
    chk(amp, 1'b1);
    chk(err, 2'b00);
    chk(d0, 16'h1234);
    @(posedge clk);
    $display("power-up test done");
  endtask

  task automatic t_motor_off();
    moj <= 1'b1;
    do_reset();
    kick();
    repeat (3) @(posedge clk);
    rd(`REG_STATUS, v);
    chk(v[3:0], 4'ha);
    @(negedge clk);
    chk(d0, 16'h0);
    chk(err, 2'b00);
    @(posedge clk);
    wr(`REG_CTRL, 32'h1);
    repeat (2) @(negedge clk);
    chk(amp, 1'b1);
    @(posedge clk);
    wr(`REG_CTRL, 32'h2);
    rd(`REG_CTRL, v);
    chk(v[1:0], 2'b10);
    @(negedge clk);
    chk(amp, 1'b0);
    @(posedge clk);
    wr(`REG_CTRL, 32'h1);
    moj <= 1'b0;
    $display("motor-off test done");
  endtask

  task automatic t_encoder();
    enc_case(8'd8, 1'b1, 1'b0, 32'd8);
    enc_case(8'd3, 1'b0, 1'b0, -32'd3);
    wr(`REG_CTRL, 32'h5);
    enc_case(8'd4, 1'b1, 1'b0, 32'd4);
    cm <= 1'b1;
    repeat (6) @(posedge clk);
    enc_case(8'd4, 1'b1, 1'b0, 32'd0);
    cm <= 1'b0;
    wr(`REG_CTRL, 32'h31);
    enc_case(8'd5, 1'b1, 1'b1, 32'd5);
    enc_case(8'd5, 1'b0, 1'b1, -32'd5);
    wr(`REG_CTRL, 32'h1);
    idx <= 2'b11;
    repeat (2) @(posedge clk);
    idx <= 2'b00;
    repeat (2) @(posedge clk);
    rd(`REG_POS0, p0);
    rd(`REG_IDXPOS0, v);
    chk(v, p0);
    rd(`REG_STATUS, v);
    chk(v[4], 1'b1);
    wr(`REG_CTRL, 32'h9);
    rd(`REG_STATUS, v);
    chk(v[4], 1'b0);
    $display("encoder test done");
  endtask

  task automatic t_modes();
    kick();
    cmd <= 16'h8400;
    wr(`REG_MODE, 32'h1);
    rd(`REG_STATUS, v);
    chk(v[5], 1'b0);
    @(negedge clk);
    chk(d0, 16'h8400);
    p0 = {16'h0, scnt};
    @(posedge clk);
    stj <= 1'b1;
    repeat (100) @(negedge clk);
    chk(d0, 16'h0);
    chk(dir, 1'b1);
    chk(scnt != p0[15:0], 1'b1);
    @(posedge clk);
    kick();
    rd(`REG_STATUS, v);
    chk(v[5], 1'b1);
    stj <= 1'b0;
    wr(`REG_MODE, 32'h2);
    repeat (2) @(negedge clk);
    chk({d1en, d1}, 17'h17c00);
    chk(slots, 2'h2);
    @(posedge clk);
    wr(`REG_MODE, 32'h0);
    repeat (2) @(negedge clk);
    chk({d1en, d0}, 17'h08400);
    @(posedge clk);
    $display("mode test done");
  endtask

  task automatic t_trip();
    rd(`REG_WD_TIMEOUT, v);
    chk(v, WD);
    for (int i = 0; i < 4; i++) begin
      kick();
      repeat (WD - 40) @(posedge clk);
    end
    kick();
    n = 0;
    while (amp === 1'b1 && n < WD + 20) begin
      @(negedge clk);
      n++;
    end
    chk(n >= WD - 2 && n <= WD + 6, 1'b1);
    chk(err, 2'b11);
    @(posedge clk);
    kick();
    repeat (3) @(negedge clk);
    chk(amp, 1'b0);
    @(posedge clk);
    rd(`REG_STATUS, v);
    chk(v[2:1], 2'b10);
    do_reset();
    kick();
    repeat (2) @(negedge clk);
    chk(amp, 1'b1);
    @(posedge clk);
    $display("watchdog trip test done");
  endtask

  ////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Whole run needs well under 10k cycles
  initial begin
    #300000;
    miscompares++;
    stop_test();
  end

  initial begin
    repeat (3) @(posedge clk);
    t_power();
    t_motor_off();
    t_encoder();
    t_modes();
    t_trip();
    stop_test();
  end
endmodule
